// File: pkg/irqtb_pkg.sv
// Shared constants for the interrupt sources and time base block
`default_nettype none
package irqtb_pkg;
    // ------------------------------------------------------------
    // Register bus geometry and offsets
    // ------------------------------------------------------------
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 8;
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_EDGE  = 4'h1;
    localparam logic [3:0] OFS_IEN   = 4'h2;
    localparam logic [3:0] OFS_IFLAG = 4'h3;
    localparam logic [3:0] OFS_GRP   = 4'h4;
    localparam logic [3:0] OFS_PSC   = 4'h5;
    localparam logic [3:0] OFS_TIME_BASE0_CONTROL  = 4'h6;
    localparam logic [3:0] OFS_TIME_BASE1_CONTROL  = 4'h7;
    localparam logic [3:0] OFS_PINCF = 4'h8;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned TB_ON_BIT   = 7;
    localparam int unsigned CONV_BIT    = 6;
    localparam int unsigned GRP_EN_LSB  = 4;
    localparam int unsigned PIN_DIR_LSB = 2;
    localparam int unsigned PIN_PU_LSB  = 4;
    localparam logic [7:0]  REG_RST     = 8'h00;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } irqtb_edge_e;
    localparam logic [1:0] PSC_SYS  = 2'b00;
    localparam logic [1:0] PSC_DIV4 = 2'b01;
    localparam logic [1:0] DIV4_TOP = 2'h3;

    // ------------------------------------------------------------
    // Sources: index order is priority order, lowest index first
    // ------------------------------------------------------------
    localparam int unsigned NSRC  = 9;
    localparam int unsigned NGRP  = 3;
    localparam int unsigned GRP0  = 6;
    localparam int unsigned TB_MIN_EXP = 8;
    localparam int unsigned TB_CNT_W   = 15;
    typedef logic [11:0] irqtb_vec_t;
    localparam logic [8:0][11:0] VEC_TAB = {
        12'h038, 12'h034, 12'h030, 12'h024, 12'h020,
        12'h010, 12'h00c, 12'h008, 12'h004
    };
endpackage : irqtb_pkg
`default_nettype wire

// File: rtl/irqtb_sync_edge.sv
// Two-stage input synchroniser with edge pulses
`timescale 1ns/1ps
`default_nettype none
module irqtb_sync_edge #(
    parameter int W = 5
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } irqtb_sync_s;
    irqtb_sync_s r, s;

    generate
        if (W < 1) begin : g_chk
            $error("irqtb_sync_edge: W must be at least 1");
        end
    endgenerate

    // First stage feeds only the second one
    always_comb begin
        s = r;
        s.s1 = i_async;
        s.s2 = r.s1;
        s.s3 = r.s2;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign o_rise = r.s2 & ~r.s3;
    assign o_fall = ~r.s2 & r.s3;
endmodule : irqtb_sync_edge
`default_nettype wire

// File: rtl/irqtb_tick.sv
// One time-base unit: free counter with selectable overflow period
`timescale 1ns/1ps
`default_nettype none
module irqtb_tick #(
    parameter int CNT_W = irqtb_pkg::TB_CNT_W
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_step,
    input  wire logic       i_on,
    input  wire logic [2:0] i_period,
    output logic            o_ovf
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             ovf;
    } irqtb_tick_s;
    irqtb_tick_s r, s;

    generate
        if (CNT_W < irqtb_pkg::TB_CNT_W) begin : g_chk
            $error("irqtb_tick: counter too narrow for longest period");
        end
    endgenerate

    // Ones in the low 8+period bits
    function automatic logic [CNT_W-1:0] mask_of(input logic [2:0] p);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1};
        mask_of = CNT_W'((one << (irqtb_pkg::TB_MIN_EXP + p)) - 1'b1);
    endfunction : mask_of

    // Counter stops and clears while off, so a restart is a full period
    always_comb begin
        s = r;
        s.ovf = 1'b0;
        if (!i_on) begin
            s.cnt = '0;
        end else if (i_step) begin
            s.cnt = r.cnt + 1'b1;
            s.ovf = (r.cnt & mask_of(i_period)) == mask_of(i_period);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign o_ovf = r.ovf;

    a_tick_off_quiet: assert property (@(posedge i_clk)
        disable iff (!i_reset_n) !i_on ##1 !i_on |-> !o_ovf)
        else $error("time base overflow while off");
endmodule : irqtb_tick
`default_nettype wire

// File: rtl/irqtb_top.sv
// Interrupt sources, time bases and vector call logic
// Function
// - Pin edge of the selected type sets that pin's request flag.
// - Pin call needs global enable, pin enable, valid edge, stack room.
// - Edge select offers rising, falling, both, or off per pin.
// - Pin is an interrupt input only if enabled, selected and input.
// - Pin service clears its flag and the global enable.
// - Pull-up selection stays active while pin is an interrupt input.
// - Comparator output change sets its flag; call when enabled.
// - Comparator service clears its flag and the global enable.
// - Conversion end sets converter flag, gated into a shared group.
// - Each time base overflow sets its flag; call when enabled.
// - Time base service clears its flag and the global enable.
// - Prescaler source: 00 system, 01 system/4, 1x sub clock.
// - Time base runs when bit 7 set; period 2^8 to 2^15.
// - Unused bits of prescaler and time base registers read zero.
// - Group flag sets when any grouped source request appears.
// - Group calls its shared vector when enabled with stack room.
// - Group service clears group flag and global enable only.
// - Taking a call pushes the program counter, loads the vector.
// - No call while the stack is full; request stays pending.
// - Any request flag rising wakes the device, enables ignored.
// - Return-from-interrupt sets the global enable again.
`timescale 1ns/1ps
`default_nettype none
module irqtb_top #(
    parameter int PC_W = 12
) (
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    input  wire logic [3:0]      i_addr,
    input  wire logic [7:0]      i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [7:0]      o_rdata,
    input  wire logic [1:0]      i_ext_irq_pins,
    output logic      [1:0]      o_pullup_en,
    input  wire logic [1:0]      i_plt_cmp,
    input  wire logic            i_conv_done,
    input  wire logic [2:0]      i_mf_req,
    input  wire logic            i_sub_clock,
    input  wire logic            i_stack_full,
    input  wire logic            i_core_ready,
    input  wire logic [PC_W-1:0] i_pc,
    input  wire logic            i_return_from_irq_instr,
    output logic                 o_call,
    output logic      [PC_W-1:0] o_call_pc,
    output logic      [11:0]     o_call_vec,
    output logic                 o_global_irq_enable,
    output logic                 o_wake
);
    localparam int N = irqtb_pkg::NSRC;

    generate
        if (PC_W < 12) begin : g_chk
            $error("irqtb_top: PC_W must hold a vector address");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic            gie;
        logic [3:0]      edge_sel;
        logic [5:0]      en;
        logic            conv_en;
        logic [N-1:0]    flag;
        logic            conv_flag;
        logic [2:0]      mf_en;
        logic [1:0]      psc;
        logic [1:0]      tb_on;
        logic [2:0]      tb_per0;
        logic [2:0]      tb_per1;
        logic [1:0]      pin_fn;
        logic [1:0]      pin_in;
        logic [1:0]      pull;
        logic [1:0]      div_cnt;
        logic [2:0]      mf_prev;
        logic [7:0]      rdata;
        logic            call;
        logic [PC_W-1:0] call_pc;
        logic [11:0]     call_vec;
        logic            wake;
    } irqtb_state_s;
    irqtb_state_s r, s;

    logic [4:0]   rise;
    logic [4:0]   fall;
    logic         step;
    logic [1:0]   tb_ovf;
    logic [N-1:0] pend;
    logic [3:0]   first;
    logic         take;

    // Lowest set index of a request vector
    function automatic logic [3:0] first_set(input logic [N-1:0] v);
        first_set = 4'hf;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction : first_set

    // ------------------------------------------------------------
    // Pin synchronisers and time bases
    // ------------------------------------------------------------
    // Sub clock is slow and asynchronous, so it is sampled, not used
    irqtb_sync_edge #(.W(5)) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_sub_clock, i_plt_cmp, i_ext_irq_pins}),
        .o_rise    (rise),
        .o_fall    (fall)
    );

    // Prescaler clock choice
    always_comb begin
        if (r.psc == irqtb_pkg::PSC_SYS) begin
            step = 1'b1;
        end else if (r.psc == irqtb_pkg::PSC_DIV4) begin
            step = (r.div_cnt == irqtb_pkg::DIV4_TOP);
        end else begin
            step = rise[4];
        end
    end

    irqtb_tick #(.CNT_W(irqtb_pkg::TB_CNT_W)) u_tb0 (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_on      (r.tb_on[0]),
        .i_period  (r.tb_per0),
        .o_ovf     (tb_ovf[0])
    );

    irqtb_tick #(.CNT_W(irqtb_pkg::TB_CNT_W)) u_tb1 (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_step    (step),
        .i_on      (r.tb_on[1]),
        .i_period  (r.tb_per1),
        .o_ovf     (tb_ovf[1])
    );

    // ------------------------------------------------------------
    // Request selection
    // ------------------------------------------------------------
    // Fixed priority; the core only takes a call at an instruction edge
    assign pend  = r.flag & {r.mf_en, r.en};
    assign first = first_set(pend);
    assign take  = r.gie && !i_stack_full && i_core_ready
                   && (pend != '0);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [N-1:0] set;
        logic [2:0]   grp;
        logic         hit;
        set = '0;
        grp = '0;
        hit = 1'b0;
        s = r;
        s.call = 1'b0;
        s.wake = 1'b0;
        s.rdata = '0;
        s.div_cnt = r.div_cnt + 1'b1;

        // Pin edges, only when the pin is set up as interrupt input
        for (int i = 0; i < 2; i++) begin
            hit = r.en[i] & r.pin_fn[i] & r.pin_in[i];
            set[i] = hit & ((r.edge_sel[2*i] & rise[i])
                     | (r.edge_sel[2*i+1] & fall[i]));
        end
        set[3:2] = rise[3:2] | fall[3:2];
        set[5:4] = tb_ovf;

        // Group flag sets on a new request from any member
        grp = i_mf_req | {2'b00, r.conv_flag & r.conv_en};
        set[8:6] = grp & ~r.mf_prev;
        s.mf_prev = grp;

        // Software writes
        if (i_wr) begin
            if (i_addr == irqtb_pkg::OFS_CTRL) begin
                s.gie = i_wdata[0];
            end else if (i_addr == irqtb_pkg::OFS_EDGE) begin
                s.edge_sel = i_wdata[3:0];
            end else if (i_addr == irqtb_pkg::OFS_IEN) begin
                s.en = i_wdata[5:0];
                s.conv_en = i_wdata[irqtb_pkg::CONV_BIT];
            end else if (i_addr == irqtb_pkg::OFS_IFLAG) begin
                s.flag[5:0] = i_wdata[5:0];
                s.conv_flag = i_wdata[irqtb_pkg::CONV_BIT];
            end else if (i_addr == irqtb_pkg::OFS_GRP) begin
                s.flag[8:6] = i_wdata[2:0];
                s.mf_en = i_wdata[irqtb_pkg::GRP_EN_LSB +: 3];
            end else if (i_addr == irqtb_pkg::OFS_PSC) begin
                s.psc = i_wdata[1:0];
            end else if (i_addr == irqtb_pkg::OFS_TIME_BASE0_CONTROL) begin
                s.tb_on[0] = i_wdata[irqtb_pkg::TB_ON_BIT];
                s.tb_per0 = i_wdata[2:0];
            end else if (i_addr == irqtb_pkg::OFS_TIME_BASE1_CONTROL) begin
                s.tb_on[1] = i_wdata[irqtb_pkg::TB_ON_BIT];
                s.tb_per1 = i_wdata[2:0];
            end else if (i_addr == irqtb_pkg::OFS_PINCF) begin
                s.pin_fn = i_wdata[1:0];
                s.pin_in = i_wdata[irqtb_pkg::PIN_DIR_LSB +: 2];
                s.pull = i_wdata[irqtb_pkg::PIN_PU_LSB +: 2];
            end
        end

        // Return from interrupt reopens the gate
        if (i_return_from_irq_instr) begin
            s.gie = 1'b1;
        end

        // Service: clear own flag only; member flags stay for software
        if (take) begin
            s.flag[first] = 1'b0;
            s.gie = 1'b0;
            s.call = 1'b1;
            s.call_pc = i_pc;
            s.call_vec = irqtb_pkg::VEC_TAB[first];
        end

        // Hardware set wins over any clear in the same cycle
        s.flag = s.flag | set;
        s.conv_flag = s.conv_flag | i_conv_done;

        // Wake on any flag rising, whatever the enables
        s.wake = ((s.flag & ~r.flag) != '0)
                 || (s.conv_flag && !r.conv_flag);

        // Read data, one cycle after the strobe; unmapped reads zero
        if (i_rd) begin
            if (i_addr == irqtb_pkg::OFS_CTRL) begin
                s.rdata = {6'h00, i_stack_full, r.gie};
            end else if (i_addr == irqtb_pkg::OFS_EDGE) begin
                s.rdata = {4'h0, r.edge_sel};
            end else if (i_addr == irqtb_pkg::OFS_IEN) begin
                s.rdata = {1'b0, r.conv_en, r.en};
            end else if (i_addr == irqtb_pkg::OFS_IFLAG) begin
                s.rdata = {1'b0, r.conv_flag, r.flag[5:0]};
            end else if (i_addr == irqtb_pkg::OFS_GRP) begin
                s.rdata = {1'b0, r.mf_en, 1'b0, r.flag[8:6]};
            end else if (i_addr == irqtb_pkg::OFS_PSC) begin
                s.rdata = {6'h00, r.psc};
            end else if (i_addr == irqtb_pkg::OFS_TIME_BASE0_CONTROL) begin
                s.rdata = {r.tb_on[0], 4'h0, r.tb_per0};
            end else if (i_addr == irqtb_pkg::OFS_TIME_BASE1_CONTROL) begin
                s.rdata = {r.tb_on[1], 4'h0, r.tb_per1};
            end else if (i_addr == irqtb_pkg::OFS_PINCF) begin
                s.rdata = {2'b00, r.pull, r.pin_in, r.pin_fn};
            end
        end
    end

    // All control state clears on reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata             = r.rdata;
    assign o_pullup_en         = r.pull;
    assign o_call              = r.call;
    assign o_call_pc           = r.call_pc;
    assign o_call_vec          = r.call_vec;
    assign o_global_irq_enable = r.gie;
    assign o_wake              = r.wake;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_div4_gap;
        step ##1 !step ##1 !step ##1 !step ##1 step;
    endsequence

    sequence seq_call_taken;
        take ##1 o_call;
    endsequence

    a_psc_div_four: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        r.psc == irqtb_pkg::PSC_DIV4 && step
        |-> seq_div4_gap
            or ##[1:4] (r.psc != irqtb_pkg::PSC_DIV4))
        else $error("divide by four prescaler spacing wrong");

    a_stack_full_block: assert property (@(posedge i_clk)
        disable iff (!i_reset_n) i_stack_full |=> !o_call)
        else $error("call issued with full stack");

    a_call_clears_gie: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        seq_call_taken |-> !o_global_irq_enable && $past(r.gie))
        else $error("global enable not cleared on call");

    a_call_vec_prio: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        take |=> o_call_vec == irqtb_pkg::VEC_TAB[$past(first)]
                 && o_call_pc == $past(i_pc))
        else $error("wrong vector or pushed counter");

    a_return_from_irq_instr_sets_gie: assert property (@(posedge i_clk)
        disable iff (!i_reset_n) i_return_from_irq_instr && !take |=> o_global_irq_enable)
        else $error("return did not set global enable");

    a_ext_edge_flag: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        r.en[0] && r.pin_fn[0] && r.pin_in[0] && rise[0]
        && r.edge_sel[0] |=> r.flag[0])
        else $error("pin edge did not set flag");

    a_ext_off_quiet: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !r.flag[0] && !r.pin_in[0] && !(i_wr && i_addr ==
        irqtb_pkg::OFS_IFLAG) |=> !r.flag[0])
        else $error("output pin raised an interrupt flag");

    a_wake_on_rise: assert property (@(posedge i_clk)
        disable iff (!i_reset_n) $rose(r.flag[4]) |-> o_wake)
        else $error("flag rise without wake");

    a_group_keeps_src: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        take && first == 4'(irqtb_pkg::GRP0) && r.conv_flag
        && !(i_wr && i_addr == irqtb_pkg::OFS_IFLAG) |=> r.conv_flag)
        else $error("group service cleared member flag");

    a_unused_zero: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        i_rd && i_addr == irqtb_pkg::OFS_PSC |=> o_rdata[7:2] == 6'h00)
        else $error("unused prescaler bits read non-zero");
endmodule : irqtb_top
`default_nettype wire

// File: rtl/irqtb_unused_placeholder_removed.sv
// Intentionally empty compile unit kept free of logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verif/irqtb_core_model.sv
// Program sequencer model: stack depth, call intake, return pulses
`timescale 1ns/1ps
`default_nettype none
module irqtb_core_model #(
    parameter int DEPTH = 1
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_call,
    input  wire logic        i_ret_req,
    input  wire logic        i_slow,
    output logic             o_stack_full,
    output logic             o_ready,
    output logic             o_return_from_irq_instr,
    output logic      [11:0] o_pc
);
    int         depth;
    logic [1:0] phase;
    // Push on call, pop on return; a full stack blocks calls
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            depth  <= 0;
            phase  <= 2'h0;
            o_return_from_irq_instr <= 1'b0;
        end else begin
            depth  <= depth + int'(i_call) - int'(o_return_from_irq_instr);
            phase  <= phase + 2'h1;
            o_return_from_irq_instr <= i_ret_req;
        end
    end
    // Slow mode reaches an instruction boundary only every 4th cycle
    assign o_ready      = !i_slow || (phase == 2'h3);
    assign o_stack_full = (depth >= DEPTH);
    assign o_pc         = 12'h3c5;
endmodule : irqtb_core_model
`default_nettype wire

// File: verif/tb_irqtb_top.sv
// Self-checking bench for the interrupt sources and time base block
`timescale 1ns/1ps
`default_nettype none
module tb_irqtb_top;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [1:0]  pins = 2'h0, pull;
    logic        conv = 1'b0, ret_req = 1'b0, slow = 1'b0;
    logic [1:0]  cmp = 2'h0, sdiv = 2'h0;
    logic [2:0]  mfq = 3'h0;
    logic        full, ready, return_from_irq_instr, call, gie, wake;
    logic [11:0] pc, cpc, vec;
    int          failures = 0, samples_checked = 0, cycles = 0;
    irqtb_top u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_ext_irq_pins(pins), .o_pullup_en(pull), .i_plt_cmp(cmp),
        .i_conv_done(conv), .i_mf_req(mfq), .i_sub_clock(sdiv[1]),
        .i_stack_full(full), .i_core_ready(ready), .i_pc(pc),
        .i_return_from_irq_instr(return_from_irq_instr), .o_call(call), .o_call_pc(cpc), .o_call_vec(vec),
        .o_global_irq_enable(gie), .o_wake(wake));
    irqtb_core_model u_core (.i_clk(clk), .i_reset_n(rst_n), .i_call(call),
        .i_ret_req(ret_req), .i_slow(slow), .o_stack_full(full),
        .o_ready(ready), .o_return_from_irq_instr(return_from_irq_instr), .o_pc(pc));
    // ----------------------------------------------------------
    // Bus, compare and call tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task automatic rd_exp(input logic [3:0] a, input logic [11:0] e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 chk(12'(rdata), e);
    endtask : rd_exp
    task automatic wait_call(input logic [11:0] e);
        for (int n = 0; n < 1200 && call !== 1'b1; n++)
            @(posedge clk) #1;
        chk(12'(call), 12'h001);
        chk(vec, e);
        chk(cpc, 12'h3c5);
        chk(12'(gie), 12'h000);
    endtask : wait_call
    // Return pulse, then drop the enable it set again
    task automatic ret();
        @(posedge clk) ret_req <= 1'b1;
        @(posedge clk) ret_req <= 1'b0;
        repeat (3) @(posedge clk);
        wr_reg(irqtb_pkg::OFS_CTRL, 8'h00);
    endtask : ret
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            rd_exp(4'(irqtb_pkg::OFS_PSC + i), 12'h000);
            wr_reg(4'(irqtb_pkg::OFS_PSC + i), 8'hff);
            rd_exp(4'(irqtb_pkg::OFS_PSC + i), i ? 12'h087 : 12'h003);
            wr_reg(4'(irqtb_pkg::OFS_PSC + i), 8'h00);
        end
        rd_exp(4'hf, 12'h000);
    endtask : t_regs
    // Every edge mode, rise and fall apart; enable set, global off
    task automatic t_edges();
        wr_reg(irqtb_pkg::OFS_PINCF, 8'h3f);
        wr_reg(irqtb_pkg::OFS_IEN, 8'h02);
        for (int m = 0; m < 4; m++) begin
            wr_reg(irqtb_pkg::OFS_EDGE, 8'(m << 2));
            wr_reg(irqtb_pkg::OFS_IFLAG, 8'h00);
            @(posedge clk) pins[1] <= 1'b1;
            repeat (3) @(posedge clk);
            #1 chk(12'(wake), 12'(m & 1));
            repeat (3) @(posedge clk);
            rd_exp(irqtb_pkg::OFS_IFLAG, 12'(m & 1) << 1);
            wr_reg(irqtb_pkg::OFS_IFLAG, 8'h00);
            @(posedge clk) pins[1] <= 1'b0;
            repeat (3) @(posedge clk);
            #1 chk(12'(wake), 12'(m >> 1));
            repeat (3) @(posedge clk);
            rd_exp(irqtb_pkg::OFS_IFLAG, 12'(m >> 1) << 1);
        end
        wr_reg(irqtb_pkg::OFS_IFLAG, 8'h00);
    endtask : t_edges
    task automatic t_pin();
        wr_reg(irqtb_pkg::OFS_PINCF, 8'h3b);
        wr_reg(irqtb_pkg::OFS_EDGE, 8'h01);
        wr_reg(irqtb_pkg::OFS_IEN, 8'h01);
        @(posedge clk) pins[0] <= 1'b1;
        repeat (6) @(posedge clk);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h000);
        @(posedge clk) pins[0] <= 1'b0;
        wr_reg(irqtb_pkg::OFS_PINCF, 8'h3f);
        wr_reg(irqtb_pkg::OFS_CTRL, 8'h01);
        @(posedge clk) pins[0] <= 1'b1;
        wait_call(12'h004);
        chk(12'(pull), 12'h003);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h000);
        rd_exp(irqtb_pkg::OFS_CTRL, 12'h002);
        ret();
        @(posedge clk) pins[0] <= 1'b0;
    endtask : t_pin
    task automatic t_conv();
        slow <= 1'b1;
        wr_reg(irqtb_pkg::OFS_IEN, 8'h40);
        wr_reg(irqtb_pkg::OFS_GRP, 8'h10);
        wr_reg(irqtb_pkg::OFS_CTRL, 8'h01);
        @(posedge clk) conv <= 1'b1;
        @(posedge clk) conv <= 1'b0;
        wait_call(12'h030);
        rd_exp(irqtb_pkg::OFS_GRP, 12'h010);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h040);
        wr_reg(irqtb_pkg::OFS_IFLAG, 8'h00);
        slow <= 1'b0;
        ret();
    endtask : t_conv
    // Comparator change either way sets its flag; a member rise sets group 1
    task automatic t_cmp();
        wr_reg(irqtb_pkg::OFS_IEN, 8'h08);
        wr_reg(irqtb_pkg::OFS_GRP, 8'h20);
        wr_reg(irqtb_pkg::OFS_CTRL, 8'h01);
        @(posedge clk) cmp[1] <= 1'b1;
        wait_call(12'h010);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h000);
        @(posedge clk) {cmp[1], mfq[1]} <= 2'b01;
        repeat (4) @(posedge clk);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h008);
        rd_exp(irqtb_pkg::OFS_GRP, 12'h022);
        @(posedge clk) mfq[1] <= 1'b0;
        wr_reg(irqtb_pkg::OFS_IFLAG, 8'h00);
        wr_reg(irqtb_pkg::OFS_GRP, 8'h00);
        ret();
    endtask : t_cmp
    // Div4 phase is free-running, so the window allows a few cycles
    task automatic t_tick(input logic [7:0] psc, input int lo);
        wr_reg(irqtb_pkg::OFS_PSC, psc);
        wr_reg(irqtb_pkg::OFS_TIME_BASE0_CONTROL, 8'h80);
        repeat (lo - 8) @(posedge clk);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h000);
        repeat (16) @(posedge clk);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h010);
        wr_reg(irqtb_pkg::OFS_TIME_BASE0_CONTROL, 8'h00);
        wr_reg(irqtb_pkg::OFS_IFLAG, 8'h00);
    endtask : t_tick
    task automatic t_prio();
        wr_reg(irqtb_pkg::OFS_IFLAG, 8'h30);
        wr_reg(irqtb_pkg::OFS_IEN, 8'h30);
        wr_reg(irqtb_pkg::OFS_CTRL, 8'h01);
        wait_call(12'h020);
        rd_exp(irqtb_pkg::OFS_CTRL, 12'h002);
        rd_exp(irqtb_pkg::OFS_IFLAG, 12'h020);
        wr_reg(irqtb_pkg::OFS_CTRL, 8'h01);
        repeat (10) @(posedge clk) #1 chk(12'(call), 12'h000);
        @(posedge clk) ret_req <= 1'b1;
        @(posedge clk) ret_req <= 1'b0;
        wait_call(12'h024);
        ret();
    endtask : t_prio
    initial forever #4 clk = ~clk;
    // Sub clock stand-in: a quarter of the bench clock, free running
    always @(posedge clk) sdiv <= sdiv + 2'h1;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_edges();
        t_pin();
        t_conv();
        t_cmp();
        t_tick(8'h00, 256);
        t_tick(8'h01, 1024);
        t_tick(8'h02, 1024);
        t_prio();
        end_of_test();
    end
endmodule : tb_irqtb_top
`default_nettype wire
